// ---- core/sdmc_host.sv ----
// host controller driving a single-rank sdram module over its command pins
// assumes software orders commands over classic wishbone; one clock domain
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module sdmc_host
  import sdmc_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_CYC,
  parameter int ROW_OPEN_MAX_CYCLES = ROW_OPEN_MAX_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic clockEnable,
  output logic moduleRankSelectN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [1:0] bankSelect,
  output logic [12:0] memAddr,
  output logic [7:0] byteLaneMask,
  output logic [63:0] dqOut,
  output logic dqOe,
  input wire logic [63:0] dqIn
);
  sdmc_state_e state, next_state;
  logic [TIMER_W-1:0] gapTimer, next_gapTimer;
  logic [2:0] strobes, next_strobes;
  logic selN, next_selN;
  logic cke, next_cke;
  logic [1:0] bank, next_bank;
  logic [12:0] addr, next_addr;
  logic [7:0] mask, next_mask;
  logic oe, next_oe;
  logic [1:0] refCount, next_refCount;
  logic [TIMER_W-1:0] rowAge [4];
  logic [TIMER_W-1:0] next_rowAge [4];
  logic [3:0] rowOpen, next_rowOpen;
  logic [TIMER_W-1:0] crossGap, next_crossGap;
  logic lapse, next_lapse;
  logic [31:0] ctrlReg, next_ctrlReg;
  logic [31:0] addrReg, next_addrReg;
  logic [31:0] modeReg, next_modeReg;
  logic [31:0] rdData, next_rdData;
  logic ack, next_ack;
  logic busy;
  logic [2:0] op;
  logic [63:0] wrData;
  logic [1:0] reqBank;
  logic [TIMER_W-1:0] reqAge;
  logic reqOpen;

  assign busy = (state != SDMC_IDLE) && (state != SDMC_SELF);
  assign op = ctrlReg[CTRL_OP_LSB +: 3];
  assign wrData = {2{addrReg}};
  assign reqBank = addrReg[14:13];
  assign reqAge = rowAge[reqBank];
  assign reqOpen = rowOpen[reqBank];

  // wishbone slave: one wait cycle, ack for one cycle
  always_comb begin
    next_ack = wb_cyc_i && wb_stb_i && !ack;
    next_ctrlReg = ctrlReg;
    next_addrReg = addrReg;
    next_modeReg = modeReg;
    next_rdData = rdData;
    // an order stays pending until the sequencer is free to act on it
    if ((state == SDMC_IDLE && gapTimer == '0) || state == SDMC_SELF) begin
      next_ctrlReg[CTRL_GO] = 1'b0;
    end
    if (next_ack && wb_we_i && wb_sel_i != 4'h0) begin
      case (wb_adr_i)
        REG_CTRL: next_ctrlReg = wb_dat_i;
        REG_ADDR: next_addrReg = wb_dat_i;
        REG_MODE: next_modeReg = wb_dat_i;
        default: next_rdData = rdData;
      endcase
    end
    if (next_ack && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: next_rdData = ctrlReg;
        REG_ADDR: next_rdData = addrReg;
        REG_MODE: next_rdData = modeReg;
        REG_STAT: next_rdData = {dqIn[23:0], lapse, rowOpen, state};
        default: next_rdData = 32'h0000_0000;
      endcase
    end
  end

  // command sequencer and timing guard
  always_comb begin
    next_state = state;
    next_gapTimer = (gapTimer != '0) ? gapTimer - 1'b1 : gapTimer;
    next_strobes = CMD_NOP;
    next_selN = 1'b0;
    next_cke = cke;
    next_bank = bank;
    next_addr = addr;
    next_mask = mask;
    next_oe = 1'b0;
    next_refCount = refCount;
    next_rowOpen = rowOpen;
    next_lapse = lapse;
    next_crossGap = (crossGap != '0) ? crossGap - 1'b1 : crossGap;
    for (int b = 0; b < 4; b++) begin
      next_rowAge[b] = (rowAge[b] != '0) ? rowAge[b] - 1'b1 : rowAge[b];
    end
    case (state)
      SDMC_POWER: begin
        next_selN = 1'b1; // inhibit while waiting
        next_cke = 1'b1;
        if (gapTimer == '0) begin
          next_strobes = CMD_PRECHARGE;
          next_selN = 1'b0;
          next_addr = 13'h0000 | (13'h0001 << AP_BIT);
          next_gapTimer = TIMER_W'(PRECHARGE_CYC);
          next_state = SDMC_INIT_PRE;
        end
      end
      SDMC_INIT_PRE, SDMC_INIT_REF: begin
        if (gapTimer == '0) begin
          if (refCount != 2'(WAKE_REFRESH_COUNT)) begin
            next_strobes = CMD_REFRESH; // two wake refreshes
            next_refCount = refCount + 1'b1;
            next_gapTimer = TIMER_W'(REFRESH_CYC);
            next_state = SDMC_INIT_REF;
          end else begin
            next_strobes = CMD_LOAD_MODE; // after idle only
            next_addr = modeReg[12:0]; // opcode on address
            next_bank = 2'h0;
            next_gapTimer = TIMER_W'(MODE_LOAD_TO_COMMAND_GAP);
            next_state = SDMC_INIT_MODE;
          end
        end
      end
      SDMC_INIT_MODE: begin
        if (gapTimer == '0) begin
          next_state = SDMC_IDLE;
          next_lapse = 1'b0;
        end
      end
      SDMC_IDLE: begin
        if (rowOpen != 4'h0 && gapTimer == '0) begin
          for (int b = 0; b < 4; b++) begin
            if (rowOpen[b] && rowAge[b] == '0) next_lapse = 1'b1;
          end
        end
        if (ctrlReg[CTRL_GO] && gapTimer == '0) begin
          next_bank = reqBank;
          next_mask = ctrlReg[CTRL_MASK_LSB +: 8];
          next_state = SDMC_WAIT;
          case (op)
            OP_ACTIVE: begin
              // rounded-up spacings
              if (!reqOpen && crossGap == '0 && reqAge == '0) begin
                next_strobes = CMD_ACTIVE;
                next_addr = addrReg[12:0];
                next_rowOpen[reqBank] = 1'b1;
                // margin so the forced close lands inside the limit
                next_rowAge[reqBank] = TIMER_W'(ROW_OPEN_MAX_CYCLES - 16);
                next_crossGap = TIMER_W'(CROSS_BANK_ACT_CYC);
                // hold off every command, precharge too
                next_gapTimer = TIMER_W'((ROW_OPEN_MIN_CYC > ROW_TO_COL_CYC) ?
                  ROW_OPEN_MIN_CYC : ROW_TO_COL_CYC);
              end else begin
                next_state = SDMC_IDLE;
              end
            end
            OP_READ, OP_WRITE: begin
              // column, bank, auto precharge bit
              next_strobes = (op == OP_READ) ? CMD_READ : CMD_WRITE;
              next_addr = {2'b00, ctrlReg[CTRL_AP], 1'b0, addrReg[8:0]};
              next_oe = (op == OP_WRITE); // data with command
              next_gapTimer = (op == OP_WRITE) ? TIMER_W'(ctrlReg[CTRL_AP] ?
                WRITE_DATA_TO_ACTIVATE_GAP : 1) : '0;
              if (ctrlReg[CTRL_AP]) begin
                next_rowOpen[reqBank] = 1'b0;
                next_rowAge[reqBank] = TIMER_W'(SAME_BANK_ACT_CYC);
              end
            end
            OP_PRECHARGE: begin
              next_strobes = CMD_PRECHARGE;
              next_addr = {2'b00, ctrlReg[CTRL_ALL], 10'h000};
              next_gapTimer = TIMER_W'(PRECHARGE_CYC);
              for (int b = 0; b < 4; b++) begin
                if (ctrlReg[CTRL_ALL] || reqBank == 2'(b)) begin
                  next_rowOpen[b] = 1'b0;
                end
              end
            end
            OP_REFRESH, OP_SELF_ENTER: begin
              // refresh needs all banks idle; address is ignored
              if (rowOpen == 4'h0) begin
                next_strobes = CMD_REFRESH;
                next_cke = (op != OP_SELF_ENTER);
                next_gapTimer = TIMER_W'(REFRESH_CYC);
                if (op == OP_SELF_ENTER) next_state = SDMC_SELF;
              end else begin
                next_state = SDMC_IDLE;
              end
            end
            default: next_state = SDMC_IDLE;
          endcase
        end
        // a row held too long: close all banks and redo the wake sequence
        if (lapse) begin
          next_refCount = 2'h0; // redo wake refreshes
          next_gapTimer = '0;
          next_rowOpen = 4'h0;
          next_strobes = CMD_NOP;
          next_oe = 1'b0;
          next_state = SDMC_POWER; // precharge-all comes first
        end
      end
      SDMC_WAIT: begin
        next_state = SDMC_IDLE; // one clock between orders
      end
      SDMC_SELF: begin
        next_cke = 1'b0;
        if (ctrlReg[CTRL_GO] && op == OP_SELF_EXIT) begin
          next_cke = 1'b1;
          next_gapTimer = TIMER_W'(SELF_REFRESH_EXIT_CYC);
          next_state = SDMC_WAIT;
        end
      end
      default: next_state = SDMC_POWER;
    endcase
  end

  // registers; mask, command and data leave straight from flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= SDMC_POWER;
      gapTimer <= TIMER_W'(POWER_UP_CYCLES);
      strobes <= CMD_NOP;
      selN <= 1'b1;
      cke <= 1'b0;
      bank <= 2'h0;
      addr <= 13'h0000;
      mask <= 8'h00;
      oe <= 1'b0;
      refCount <= 2'h0;
      rowOpen <= 4'h0;
      crossGap <= '0;
      lapse <= 1'b0;
      for (int b = 0; b < 4; b++) rowAge[b] <= '0;
      ctrlReg <= 32'h0000_0000;
      addrReg <= 32'h0000_0000;
      modeReg <= 32'h0000_0022;
      rdData <= 32'h0000_0000;
      ack <= 1'b0;
    end else begin
      state <= next_state;
      gapTimer <= next_gapTimer;
      strobes <= next_strobes;
      selN <= next_selN;
      cke <= next_cke;
      bank <= next_bank;
      addr <= next_addr;
      mask <= next_mask; // high bit masks lane
      oe <= next_oe;
      refCount <= next_refCount;
      rowOpen <= next_rowOpen;
      crossGap <= next_crossGap;
      lapse <= next_lapse;
      for (int b = 0; b < 4; b++) rowAge[b] <= next_rowAge[b];
      ctrlReg <= next_ctrlReg;
      addrReg <= next_addrReg;
      modeReg <= next_modeReg;
      rdData <= next_rdData;
      ack <= next_ack;
    end
  end

  assign clockEnable = cke;
  assign moduleRankSelectN = selN;
  assign {rasN, casN, weN} = strobes;
  assign bankSelect = bank;
  assign memAddr = addr;
  assign byteLaneMask = mask;
  assign dqOut = wrData;
  assign dqOe = oe;
  assign wb_dat_o = rdData;
  assign wb_ack_o = ack;

  // checks on the driven command stream
  property p_mode_gap;
    @(posedge clk) disable iff (sys_rst)
    (!selN && strobes == CMD_LOAD_MODE) |=>
      !(!selN && (strobes == CMD_ACTIVE || strobes == CMD_REFRESH));
  endproperty
  a_mode_gap: assert property (p_mode_gap)
    else $error("command too soon after mode load");
  property p_cke_high;
    @(posedge clk) disable iff (sys_rst)
    (!selN && strobes != CMD_NOP && state != SDMC_SELF) |-> cke;
  endproperty
  a_cke_high: assert property (p_cke_high)
    else $error("clock enable low with command");
  property p_row_to_col;
    @(posedge clk) disable iff (sys_rst)
    (!selN && strobes == CMD_ACTIVE) |=>
      !(!selN && (strobes == CMD_READ || strobes == CMD_WRITE));
  endproperty
  a_row_to_col: assert property (p_row_to_col)
    else $error("column command too soon after activate");
  property p_write_data;
    @(posedge clk) disable iff (sys_rst)
    (!selN && strobes == CMD_WRITE) |-> oe;
  endproperty
  a_write_data: assert property (p_write_data)
    else $error("write data absent with write");
  property p_ap_write;
    @(posedge clk) disable iff (sys_rst)
    (!selN && strobes == CMD_WRITE && addr[AP_BIT]) |=>
      !(!selN && strobes == CMD_ACTIVE) [*3];
  endproperty
  a_ap_write: assert property (p_ap_write)
    else $error("activate too soon after auto precharge write");
  property p_wr_pre;
    @(posedge clk) disable iff (sys_rst)
    (!selN && strobes == CMD_WRITE) |=>
      !(!selN && strobes == CMD_PRECHARGE);
  endproperty
  a_wr_pre: assert property (p_wr_pre)
    else $error("precharge too soon after write");
  property p_row_min;
    @(posedge clk) disable iff (sys_rst)
    (!selN && strobes == CMD_ACTIVE) |=>
      !(!selN && strobes == CMD_PRECHARGE) [*4];
  endproperty
  a_row_min: assert property (p_row_min)
    else $error("precharge too soon after activate");
  property p_power_wait;
    @(posedge clk) disable iff (sys_rst)
    (state == SDMC_POWER && gapTimer != '0) |=> selN;
  endproperty
  a_power_wait: assert property (p_power_wait)
    else $error("command during power-up wait");
  property p_self_cke;
    @(posedge clk) disable iff (sys_rst)
    (state == SDMC_SELF && $past(state) == SDMC_SELF) |-> !cke;
  endproperty
  a_self_cke: assert property (p_self_cke)
    else $error("clock enable high in self refresh");
endmodule : sdmc_host

// ---- core/sdmc_pkg.sv ----
// package for the sdram module command controller
// assumes a 125 MHz system clock and a single-rank module with four banks
package sdmc_pkg;
  localparam int CLK_PS = 8000;
  // nanosecond spacings, fastest grade, and derived clock counts
  localparam int ROW_TO_COL_NS = 15;
  localparam int ROW_OPEN_MIN_NS = 37;
  localparam int ROW_OPEN_MAX_NS = 120000;
  localparam int SAME_BANK_ACT_NS = 60;
  localparam int CROSS_BANK_ACT_NS = 14;
  localparam int REFRESH_PERIOD_NS = 66;
  localparam int PRECHARGE_PERIOD_NS = 15;
  localparam int SELF_REFRESH_EXIT_NS = 67;
  localparam int POWER_UP_US = 100;
  localparam int ROW_TO_COL_CYC = (ROW_TO_COL_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ROW_OPEN_MIN_CYC =
    (ROW_OPEN_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ROW_OPEN_MAX_CYC = (ROW_OPEN_MAX_NS * 1000) / CLK_PS;
  localparam int SAME_BANK_ACT_CYC =
    (SAME_BANK_ACT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CROSS_BANK_ACT_CYC =
    (CROSS_BANK_ACT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int REFRESH_CYC =
    (REFRESH_PERIOD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PRECHARGE_CYC =
    (PRECHARGE_PERIOD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SELF_REFRESH_EXIT_CYC =
    (SELF_REFRESH_EXIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int POWER_UP_CYC = (POWER_UP_US * 1000000 + CLK_PS - 1) / CLK_PS;
  // clock-count gaps
  localparam int WRITE_DATA_TO_ACTIVATE_GAP = 4;
  localparam int WRITE_DATA_TO_PRECHARGE_GAP = 2;
  localparam int MODE_LOAD_TO_COMMAND_GAP = 2;
  localparam int WAKE_REFRESH_COUNT = 2;
  localparam int TIMER_W = 16;
  // strobe codes {ras, cas, we}, active low
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACTIVE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_BURST_STOP = 3'h6;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
  localparam int AP_BIT = 10;
  // wishbone register map, word offsets in bytes
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_MODE = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  // control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO = 4;
  localparam int CTRL_AP = 5;
  localparam int CTRL_ALL = 6;
  localparam int CTRL_MASK_LSB = 8;
  // operation codes written to the control register
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_ACTIVE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_PRECHARGE = 3'h4;
  localparam logic [2:0] OP_REFRESH = 3'h5;
  localparam logic [2:0] OP_SELF_ENTER = 3'h6;
  localparam logic [2:0] OP_SELF_EXIT = 3'h7;
  typedef enum logic [2:0] {
    SDMC_POWER = 3'b000,
    SDMC_INIT_PRE = 3'b001,
    SDMC_INIT_REF = 3'b010,
    SDMC_INIT_MODE = 3'b011,
    SDMC_IDLE = 3'b100,
    SDMC_WAIT = 3'b101,
    SDMC_SELF = 3'b110
  } sdmc_state_e;
endpackage : sdmc_pkg

// ---- sim/sdmc_dev_model.sv ----
// behavioural model of a single-rank sdram module with four banks
// assumes command pins change only just after rising edges
`timescale 1ns/1ps
module sdmc_dev_model
  import sdmc_pkg::*;
(
  input wire logic clk,
  input wire logic clockEnable,
  input wire logic moduleRankSelectN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [1:0] bankSelect,
  input wire logic [12:0] memAddr,
  input wire logic [7:0] byteLaneMask,
  input wire logic [63:0] dqOut,
  input wire logic dqOe,
  output logic [63:0] dqIn
);
  logic [12:0] modeWord = 13'h0000;
  logic [3:0] bankOpen = 4'h0;
  logic [12:0] refreshRow = 13'h0000;
  logic selfRefresh = 1'b0;
  logic ckeSeen = 1'b0;
  logic [2:0] pipeValid = 3'h0;
  logic [63:0] lastOut = 64'h0;
  logic [63:0] store [0:7];
  logic [63:0] pipeData [0:2];
  logic [7:0] maskDly [0:1];
  logic [2:0] code;
  logic [63:0] outWord;
  logic outHit;
  assign code = {rasN, casN, weN};
  // power-up contents; known values keep the read path free of unknowns
  initial begin
    for (int i = 0; i < 8; i++) begin
      store[i] = {8{8'(i)}};
    end
    pipeData = '{default: 64'h0};
    maskDly = '{default: 8'h0};
  end
  // decode one command per edge while the clock is enabled
  always @(posedge clk) begin
    ckeSeen <= clockEnable;
    pipeValid <= {pipeValid[1:0], 1'b0};
    pipeData[1] <= pipeData[0];
    pipeData[2] <= pipeData[1];
    maskDly[0] <= byteLaneMask;
    maskDly[1] <= maskDly[0];
    lastOut <= dqIn;
    if (selfRefresh && clockEnable) begin
      selfRefresh <= 1'b0;
    end
    if (!moduleRankSelectN && ckeSeen && !selfRefresh) begin
      case (code)
        CMD_ACTIVE: bankOpen[bankSelect] <= 1'b1;
        CMD_READ: begin
          pipeData[0] <= store[memAddr[2:0]];
          pipeValid[0] <= 1'b1;
          if (memAddr[AP_BIT]) bankOpen[bankSelect] <= 1'b0;
        end
        CMD_WRITE: begin
          for (int l = 0; l < 8; l++) begin
            if (!byteLaneMask[l]) begin
              store[memAddr[2:0]][l*8 +: 8] <= dqOut[l*8 +: 8];
            end
          end
          if (memAddr[AP_BIT]) bankOpen[bankSelect] <= 1'b0;
        end
        CMD_PRECHARGE: begin
          if (memAddr[AP_BIT]) bankOpen <= 4'h0;
          else bankOpen[bankSelect] <= 1'b0;
        end
        CMD_REFRESH: begin
          refreshRow <= refreshRow + 13'h0001;
          selfRefresh <= !clockEnable;
        end
        CMD_LOAD_MODE: modeWord <= memAddr;
        default: ;
      endcase
    end
  end
  // one-beat bursts end before a precharge could float them
  // read beat after the latency; masked or idle lanes never hold old data
  always_comb begin
    outHit = (modeWord[6:4] == 3'h2) ? pipeValid[1] :
             (modeWord[6:4] == 3'h3) && pipeValid[2];
    outWord = (modeWord[6:4] == 3'h2) ? pipeData[1] : pipeData[2];
    dqIn = ~lastOut;
    for (int l = 0; l < 8; l++) begin
      if (outHit && !maskDly[1][l]) begin
        dqIn[l*8 +: 8] = outWord[l*8 +: 8];
      end
    end
  end
endmodule : sdmc_dev_model

// ---- sim/sdmc_host_test.sv ----
// self-checking bench for the sdram command controller
// assumes the device model on the far side; one 125 MHz clock
`timescale 1ns/1ps
module sdmc_host_test
  import sdmc_pkg::*;
;
  typedef struct {
    int at;
    logic [2:0] code;
    logic [1:0] bank;
    logic [12:0] addr;
    logic cke;
    logic oe;
    logic [63:0] dq;
    logic [7:0] mask;
  } sdmc_cmd_s;
  localparam int PUP = 20;
  localparam int RMAX = 200;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, clockEnable, moduleRankSelectN, rasN, casN, weN, dqOe;
  logic [1:0] bankSelect;
  logic [12:0] memAddr;
  logic [7:0] byteLaneMask;
  logic [63:0] dqOut, dqIn;
  int cyc = 0;
  int fails = 0;
  int checks_done = 0;
  int relAt = 0;
  sdmc_cmd_s cmdQ[$];
  sdmc_host #(.POWER_UP_CYCLES(PUP), .ROW_OPEN_MAX_CYCLES(RMAX)) i_sdmc_host (
    .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .clockEnable, .moduleRankSelectN,
    .rasN, .casN, .weN, .bankSelect, .memAddr, .byteLaneMask, .dqOut,
    .dqOe, .dqIn);
  sdmc_dev_model i_sdmc_dev_model (
    .clk, .clockEnable, .moduleRankSelectN, .rasN, .casN, .weN,
    .bankSelect, .memAddr, .byteLaneMask, .dqOut, .dqOe, .dqIn);
  always #4 clk = ~clk;
  // cycle count; a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // log every selected command at mid-cycle, clear of edge races
  always @(negedge clk) begin
    if (!sys_rst && moduleRankSelectN === 1'b0 &&
        {rasN, casN, weN} !== CMD_NOP)
      cmdQ.push_back('{cyc, {rasN, casN, weN}, bankSelect, memAddr,
                       clockEnable, dqOe, dqOut, byteLaneMask});
  end
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic ok(input string what, input logic cond);
    check(what, 64'(cond), 64'h1);
  endtask : ok
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // look for ack mid-cycle, then act on the edge that samples it high
    @(negedge clk);
    while (wb_ack_o !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n == 100) fails++;
    @(posedge clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic pop(output sdmc_cmd_s r);
    int n;
    n = 0;
    while (cmdQ.size() == 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    ok("command issued", cmdQ.size() > 0);
    if (cmdQ.size() > 0) r = cmdQ.pop_front();
    else r.code = CMD_NOP;
  endtask : pop
  task automatic order(input logic [31:0] a, input logic [31:0] c,
                       input logic [2:0] code, output sdmc_cmd_s r);
    logic [31:0] q;
    wb(1'b1, REG_ADDR, a, q);
    wb(1'b1, REG_CTRL, c, q);
    pop(r);
    check("command code", 64'(r.code), 64'(code));
  endtask : order
  task automatic test_init();
    sdmc_cmd_s r, p;
    pop(p);
    ok("power-up wait", p.at - relAt >= PUP);
    check("init close", 64'(p.code), 64'(CMD_PRECHARGE));
    ok("init all banks", p.addr[AP_BIT] === 1'b1);
    pop(r);
    check("refresh one", 64'({r.code, r.cke}),
          64'({CMD_REFRESH, 1'b1}));
    ok("close to refresh", r.at - p.at >= PRECHARGE_CYC);
    pop(p);
    check("refresh two", 64'({p.code, p.cke}),
          64'({CMD_REFRESH, 1'b1}));
    ok("refresh spacing", p.at - r.at >= REFRESH_CYC);
    pop(r);
    check("mode load", 64'({r.code, r.addr}),
          64'({CMD_LOAD_MODE, 13'h0022}));
    ok("refresh to mode", r.at - p.at >= REFRESH_CYC);
    $display("test init done");
  endtask : test_init
  task automatic test_regs();
    logic [31:0] q;
    wb(1'b0, REG_MODE, 32'h0, q);
    check("mode reset", 64'(q), 64'h22);
    wb(1'b0, 4'h2, 32'h0, q);
    check("unmapped read", 64'(q), 64'h0);
    wb(1'b0, REG_STAT, 32'h0, q);
    check("idle state", 64'(q[6:0]), 64'({4'h0, SDMC_IDLE}));
    $display("test regs done");
  endtask : test_regs
  task automatic test_access();
    sdmc_cmd_s a, b, r;
    order(32'h0000_2123, 32'h0000_0011, CMD_ACTIVE, a);
    check("act row", 64'({a.bank, a.addr}), 64'({2'h1, 13'h0123}));
    order(32'h0000_2005, 32'h0000_0f13, CMD_WRITE, b);
    check("write col", 64'({b.bank, b.addr[AP_BIT], b.addr[8:0]}),
          64'({2'h1, 1'b0, 9'h005}));
    ok("act to write", b.at - a.at >= ROW_TO_COL_CYC);
    check("write data", b.dq, {2{32'h0000_2005}});
    check("write mask", 64'({b.oe, b.mask}), 64'({1'b1, 8'h0f}));
    order(32'h0000_2006, 32'h0000_0012, CMD_READ, r);
    ok("write to read",
       r.at - b.at >= 1 && r.addr[AP_BIT] === 1'b0);
    order(32'h0000_2007, 32'h0000_0033, CMD_WRITE, b);
    ok("auto close write", b.addr[AP_BIT] === 1'b1);
    repeat (SAME_BANK_ACT_CYC) @(posedge clk); // early activates are dropped
    order(32'h0000_2055, 32'h0000_0011, CMD_ACTIVE, r);
    ok("write to act", r.at - b.at >= WRITE_DATA_TO_ACTIVATE_GAP);
    ok("same bank act", r.at - a.at >= SAME_BANK_ACT_CYC);
    order(32'h0000_4033, 32'h0000_0011, CMD_ACTIVE, a);
    ok("cross bank act", a.at - r.at >= CROSS_BANK_ACT_CYC);
    order(32'h0000_4000, 32'h0000_0014, CMD_PRECHARGE, r);
    ok("row open min", r.at - a.at >= ROW_OPEN_MIN_CYC);
    check("one bank", 64'({r.bank, r.addr[AP_BIT]}),
          64'({2'h2, 1'b0}));
    order(32'h0000_0000, 32'h0000_0054, CMD_PRECHARGE, r);
    ok("all banks", r.addr[AP_BIT] === 1'b1);
    $display("test access done");
  endtask : test_access
  // leaves bank 0 open so that the lapse test finds a row held too long
  task automatic test_modes();
    sdmc_cmd_s r;
    logic [31:0] q;
    int n, t;
    n = 0;
    order(32'h0000_0000, 32'h0000_0015, CMD_REFRESH, r);
    ok("auto refresh", r.cke === 1'b1);
    order(32'h0000_0000, 32'h0000_0016, CMD_REFRESH, r);
    ok("self entry", r.cke === 1'b0);
    wb(1'b0, REG_STAT, 32'h0, q);
    check("self state", 64'(q[2:0]), 64'(SDMC_SELF));
    wb(1'b1, REG_CTRL, 32'h0000_0017, q);
    while (clockEnable !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    ok("self exit cke", clockEnable === 1'b1);
    t = cyc;
    order(32'h0000_0001, 32'h0000_0011, CMD_ACTIVE, r);
    ok("self exit gap", r.at - t >= SELF_REFRESH_EXIT_CYC);
    $display("test modes done");
  endtask : test_modes
  task automatic test_lapse();
    sdmc_cmd_s r;
    logic [31:0] q;
    pop(r);
    check("lapse close", 64'({r.code, r.addr[AP_BIT]}),
          64'({CMD_PRECHARGE, 1'b1}));
    wb(1'b0, REG_STAT, 32'h0, q);
    check("lapse flag", 64'(q[7]), 64'h1);
    for (int i = 0; i < WAKE_REFRESH_COUNT; i++) begin
      pop(r);
      check("wake refresh", 64'(r.code), 64'(CMD_REFRESH));
    end
    pop(r);
    check("wake mode", 64'(r.code), 64'(CMD_LOAD_MODE));
    $display("test lapse done");
  endtask : test_lapse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    relAt = cyc;
    test_init();
    test_regs();
    test_access();
    test_modes();
    test_lapse();
    tally_and_finish();
  end
endmodule : sdmc_host_test
